//--- pmc_top.sv
// Purpose: Power-managed mode control, clock source switching and power-up delay sequencing.
// Assumes: APB slave with one wait state; sleep and wake pulses come from the core clock domain.
// Notes: Device clocks are one-cycle enable pulses on the active source's sampled rising edge.
//
// The APB register port and the register offsets were decided locally.
module pmc_top
    import pmc_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES_P = PLL_LOCK_CYCLES,
    parameter int POWER_UP_CYCLES_P = POWER_UP_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_osc_pin_in,
    input wire logic i_t1_osc_in,
    input wire logic i_internal_lf_osc_in,
    input wire logic [3:0] i_primary_osc_config,
    input wire logic i_power_up_timer_enable_n,
    input wire logic i_two_speed_enable,
    input wire logic i_wdt_enable,
    input wire logic i_fscm_enable,
    input wire logic i_sleep_exec,
    input wire logic i_wake,
    input wire logic i_port_bit6_out,
    input wire logic i_port_bit6_oe_n,
    output logic o_device_reset,
    output logic o_cpu_ready,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_pri_osc_en,
    output logic o_t1_osc_en,
    output logic o_internal_lf_osc_en,
    output logic o_osc_pin_out,
    output logic o_osc_pin_out_oe_n
);
    function automatic logic [1:0] src_of(input logic [1:0] sel);
        if (sel[1]) begin
            return SRC_INT;
        end else if (sel[0]) begin
            return SRC_T1;
        end else begin
            return SRC_PRI;
        end
    endfunction : src_of

    function automatic logic is_crystal(input logic [3:0] cfg);
        return (cfg == CFG_LOW_SPEED_CRYSTAL) || (cfg == CFG_HIGH_SPEED_CRYSTAL)
            || (cfg == CFG_PLL_CRYSTAL);
    endfunction : is_crystal

    function automatic logic is_clkout(input logic [3:0] cfg);
        return (cfg == CFG_EXT_CLOCK_CLKOUT) || (cfg == CFG_INTERNAL_CLKOUT);
    endfunction : is_clkout

    logic [1:0] rst_sync;
    logic rst_n;
    logic [2:0] osc_raw;
    logic [2:0] osc_s1;
    logic [2:0] osc_s2;
    logic [2:0] osc_s3;
    logic [2:0] osc_edge;
    logic [7:0] cfg_s1;
    logic [7:0] cfg_s2;
    logic [3:0] osc_cfg;
    logic power_up_en_n;
    logic two_speed;
    logic wdt_en;
    logic fscm_en;
    logic [2:0] src_edge;
    logic idle_enable;
    logic [1:0] clock_select;
    logic timer1_osc_enable;
    logic [1:0] cur_src;
    logic [1:0] new_src;
    logic [1:0] tgt_src;
    pmc_sw_state_e sw_state;
    pmc_pm_mode_e pm_mode;
    logic [1:0] sw_cnt;
    logic [10:0] startup_cnt;
    logic [DLY_W-1:0] pll_cnt;
    logic [DLY_W-1:0] power_up_cnt;
    logic [DLY_W-1:0] ready_cnt;
    logic pri_on;
    logic startup_done;
    logic pll_done;
    logic pri_ready;
    logic power_up_done;
    logic ready_done;
    logic dev_rst;
    logic dev_tick;
    logic primary_running_flag;
    logic secondary_running_flag;
    logic [1:0] div4;
    logic apb_access;
    logic apb_done;
    logic [31:0] next_prdata;
    logic next_slverr;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    assign osc_raw = {i_internal_lf_osc_in, i_t1_osc_in, i_osc_pin_in};

    // Each oscillator pin passes two flip-flops; a third stage gives the edge.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_osc_sync
            always_ff @(posedge i_sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    osc_s1[gi] <= 1'b0;
                    osc_s2[gi] <= 1'b0;
                    osc_s3[gi] <= 1'b0;
                end else begin
                    osc_s1[gi] <= osc_raw[gi];
                    osc_s2[gi] <= osc_s1[gi];
                    osc_s3[gi] <= osc_s2[gi];
                end
            end
            assign osc_edge[gi] = osc_s2[gi] & ~osc_s3[gi];
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_s1 <= 8'h00;
            cfg_s2 <= 8'h00;
        end else begin
            cfg_s1 <= {i_primary_osc_config, i_power_up_timer_enable_n, i_two_speed_enable,
                       i_wdt_enable, i_fscm_enable};
            cfg_s2 <= cfg_s1;
        end
    end
    assign osc_cfg = cfg_s2[7:4];
    assign power_up_en_n = cfg_s2[3];
    assign two_speed = cfg_s2[2];
    assign wdt_en = cfg_s2[1];
    assign fscm_en = cfg_s2[0];

    // In internal primary modes the primary clock is the low-frequency oscillator.
    assign src_edge[SRC_PRI] = ((osc_cfg == CFG_INTERNAL_IO) || (osc_cfg == CFG_INTERNAL_CLKOUT))
        ? osc_edge[SRC_INT] : osc_edge[SRC_PRI];
    assign src_edge[SRC_T1] = osc_edge[SRC_T1];
    assign src_edge[SRC_INT] = osc_edge[SRC_INT];

    assign tgt_src = src_of(clock_select);
    assign pri_on = (pm_mode != PM_SLEEP)
        && ((cur_src == SRC_PRI) || ((sw_state != ST_RUN) && (new_src == SRC_PRI)));

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            startup_cnt <= 11'h000;
        end else if (!pri_on || !is_crystal(osc_cfg)) begin
            startup_cnt <= 11'h000;
        end else if (src_edge[SRC_PRI] && (startup_cnt != STARTUP_COUNT)) begin
            startup_cnt <= startup_cnt + 11'h001;
        end
    end
    assign startup_done = !is_crystal(osc_cfg) || (startup_cnt == STARTUP_COUNT);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_cnt <= '0;
        end else if (!pri_on || !startup_done || (osc_cfg != CFG_PLL_CRYSTAL)) begin
            pll_cnt <= '0;
        end else if (pll_cnt != DLY_W'(PLL_LOCK_CYCLES_P)) begin
            pll_cnt <= pll_cnt + 1'b1;
        end
    end
    assign pll_done = (osc_cfg != CFG_PLL_CRYSTAL) || (pll_cnt == DLY_W'(PLL_LOCK_CYCLES_P));
    assign pri_ready = pri_on && startup_done && pll_done;

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_up_cnt <= '0;
        end else if (!power_up_en_n && (power_up_cnt != DLY_W'(POWER_UP_CYCLES_P))) begin
            power_up_cnt <= power_up_cnt + 1'b1;
        end
    end
    assign power_up_done = power_up_en_n || (power_up_cnt == DLY_W'(POWER_UP_CYCLES_P));

    // The ready delay restarts on every wake from idle or sleep and runs alongside the reset delays.
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_cnt <= '0;
        end else if (i_wake && (pm_mode != PM_RUN)) begin
            ready_cnt <= '0;
        end else if (ready_cnt != DLY_W'(READY_DELAY_CYCLES)) begin
            ready_cnt <= ready_cnt + 1'b1;
        end
    end
    assign ready_done = (ready_cnt == DLY_W'(READY_DELAY_CYCLES));

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_rst <= 1'b1;
        end else if (dev_rst && power_up_done && (two_speed || pri_ready)) begin
            dev_rst <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_enable <= 1'b0;
            clock_select <= 2'h0;
            timer1_osc_enable <= 1'b0;
        end else if (apb_done && i_pwrite && (i_paddr == OSC_CTRL_ADDR)) begin
            idle_enable <= i_pwdata[IDLE_EN_BIT];
            clock_select <= i_pwdata[1:0];
        end else if (apb_done && i_pwrite && (i_paddr == T1_CTRL_ADDR)) begin
            timer1_osc_enable <= i_pwdata[T1_OSC_EN_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_mode <= PM_RUN;
        end else if ((pm_mode == PM_RUN) && i_sleep_exec && o_cpu_ready && (sw_state == ST_RUN)) begin
            pm_mode <= idle_enable ? PM_IDLE : PM_SLEEP;
        end else if ((pm_mode != PM_RUN) && i_wake) begin
            pm_mode <= PM_RUN;
        end
    end

    // Clock switch sequencer; the old source runs while a cold primary warms up.
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_state <= ST_RUN;
            cur_src <= SRC_PRI;
            new_src <= SRC_PRI;
            sw_cnt <= 2'h0;
        end else if (dev_rst) begin
            cur_src <= two_speed ? SRC_INT : SRC_PRI;
            sw_state <= ST_RUN;
        end else begin
            case (sw_state)
                ST_RUN: begin
                    if ((pm_mode != PM_SLEEP) && (tgt_src != cur_src)
                            && !((tgt_src == SRC_T1) && !timer1_osc_enable)) begin
                        new_src <= tgt_src;
                        sw_cnt <= 2'h0;
                        sw_state <= ((tgt_src == SRC_PRI) && !pri_ready) ? ST_WARM : ST_GATE_OLD;
                    end
                end
                ST_WARM: begin
                    if (pri_ready) begin
                        sw_state <= ST_GATE_OLD;
                    end
                end
                ST_GATE_OLD: begin
                    if (src_edge[cur_src]) begin
                        if (sw_cnt == SW_OLD_CYCLES - 2'h1) begin
                            sw_cnt <= 2'h0;
                            sw_state <= ST_SYNC_NEW;
                        end else begin
                            sw_cnt <= sw_cnt + 2'h1;
                        end
                    end
                end
                ST_SYNC_NEW: begin
                    // A Timer1 source that has not started gives no edges, so clocks stay held.
                    if (src_edge[new_src]) begin
                        if (sw_cnt == SW_NEW_CYCLES - 2'h1) begin
                            cur_src <= new_src;
                            sw_state <= ST_RUN;
                        end else begin
                            sw_cnt <= sw_cnt + 2'h1;
                        end
                    end
                end
                default: begin
                    sw_state <= ST_RUN;
                end
            endcase
        end
    end

    // Ticks come only from the active source and never during the pause.
    assign dev_tick = src_edge[cur_src] && !dev_rst && (pm_mode != PM_SLEEP)
        && ((sw_state == ST_RUN) || (sw_state == ST_WARM))
        && ((cur_src != SRC_PRI) || pri_ready);

    assign primary_running_flag = (cur_src == SRC_PRI) && pri_ready && (pm_mode != PM_SLEEP);
    assign secondary_running_flag = (cur_src == SRC_T1) && (pm_mode != PM_SLEEP);

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_cpu_clk_en <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_device_reset <= 1'b1;
            o_cpu_ready <= 1'b0;
        end else begin
            o_cpu_clk_en <= dev_tick && (pm_mode == PM_RUN) && ready_done;
            o_periph_clk_en <= dev_tick;
            o_device_reset <= dev_rst;
            o_cpu_ready <= !dev_rst && ready_done;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pri_osc_en <= 1'b0;
            o_t1_osc_en <= 1'b0;
            o_internal_lf_osc_en <= 1'b0;
        end else begin
            o_pri_osc_en <= pri_on;
            o_t1_osc_en <= timer1_osc_enable;
            o_internal_lf_osc_en <= wdt_en || fscm_en || two_speed
                || ((pm_mode != PM_SLEEP) && ((cur_src == SRC_INT) || (new_src == SRC_INT)
                || (osc_cfg == CFG_INTERNAL_IO) || (osc_cfg == CFG_INTERNAL_CLKOUT)));
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div4 <= 2'h0;
        end else if (dev_tick) begin
            div4 <= div4 + 2'h1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_osc_pin_out <= 1'b0;
            o_osc_pin_out_oe_n <= 1'b1;
        end else if (is_clkout(osc_cfg)) begin
            o_osc_pin_out <= (pm_mode == PM_SLEEP) ? 1'b0 : div4[1];
            o_osc_pin_out_oe_n <= 1'b0;
        end else if (!is_crystal(osc_cfg)) begin
            o_osc_pin_out <= i_port_bit6_out;
            o_osc_pin_out_oe_n <= i_port_bit6_oe_n;
        end else begin
            o_osc_pin_out <= 1'b0;
            o_osc_pin_out_oe_n <= 1'b1;
        end
    end

    // APB slave: one wait state so that read data leaves a flip-flop.
    assign apb_access = i_psel && i_penable;
    assign apb_done = apb_access && o_pready;

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (i_paddr)
            OSC_CTRL_ADDR: begin
                next_prdata[IDLE_EN_BIT] = idle_enable;
                next_prdata[PRI_FLAG_BIT] = primary_running_flag;
                next_prdata[1:0] = clock_select;
            end
            T1_CTRL_ADDR: begin
                next_prdata[SEC_FLAG_BIT] = secondary_running_flag;
                next_prdata[T1_OSC_EN_BIT] = timer1_osc_enable;
            end
            PM_STATUS_ADDR: begin
                next_prdata[9:0] = {dev_rst, o_cpu_ready, pm_mode, sw_state, new_src, cur_src};
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (apb_access && !o_pready) begin
            o_pready <= 1'b1;
            o_prdata <= i_pwrite ? 32'h0000_0000 : next_prdata;
            o_pslverr <= next_slverr;
        end else begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end
endmodule : pmc_top

//--- pmc_pkg.sv
// Purpose: Shared constants and types for the power mode and clock switch controller.
// Assumes: 100 MHz system clock; oscillators arrive as pins and are sampled, not used as clocks.
// Notes: Notes on behaviour follow.
package pmc_pkg;
    localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] T1_CTRL_ADDR = 8'h04;
    localparam logic [7:0] PM_STATUS_ADDR = 8'h08;

    localparam int IDLE_EN_BIT = 7;
    localparam int PRI_FLAG_BIT = 3;
    localparam int SEC_FLAG_BIT = 6;
    localparam int T1_OSC_EN_BIT = 3;

    localparam logic [10:0] STARTUP_COUNT = 11'h400;
    localparam logic [1:0] SW_OLD_CYCLES = 2'h2;
    localparam logic [1:0] SW_NEW_CYCLES = 2'h3;

    localparam int CLK_PERIOD_NS = 10;
    localparam int PLL_LOCK_TIME_MS = 2;
    localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int POWER_UP_TIME_US = 1000;
    localparam int POWER_UP_CYCLES = POWER_UP_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int READY_DELAY_NS = 200;
    localparam int READY_DELAY_CYCLES = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W = 24;

    // Source indices used for the edge vector and the active source.
    localparam logic [1:0] SRC_PRI = 2'h0;
    localparam logic [1:0] SRC_T1 = 2'h1;
    localparam logic [1:0] SRC_INT = 2'h2;

    // Primary oscillator configuration codes.
    localparam logic [3:0] CFG_LOW_SPEED_CRYSTAL = 4'h0;
    localparam logic [3:0] CFG_HIGH_SPEED_CRYSTAL = 4'h1;
    localparam logic [3:0] CFG_PLL_CRYSTAL = 4'h2;
    localparam logic [3:0] CFG_EXT_CLOCK_IO = 4'h3;
    localparam logic [3:0] CFG_EXT_CLOCK_CLKOUT = 4'h4;
    localparam logic [3:0] CFG_INTERNAL_IO = 4'h5;
    localparam logic [3:0] CFG_INTERNAL_CLKOUT = 4'h6;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_WARM = 2'b01,
        ST_GATE_OLD = 2'b10,
        ST_SYNC_NEW = 2'b11
    } pmc_sw_state_e;

    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_IDLE = 2'b01,
        PM_SLEEP = 2'b10
    } pmc_pm_mode_e;
endpackage : pmc_pkg

//--- pmc_assertions.sv
// Purpose: Port checker for the power mode and clock switch controller.
// Assumes: One clock domain; the raw asynchronous reset disables every check.
// Notes: Bound into pmc_top after the module.
module pmc_checker (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_device_reset,
    input wire logic o_cpu_ready,
    input wire logic o_cpu_clk_en,
    input wire logic o_periph_clk_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    sequence s_wait_answer;
        i_psel && i_penable && !o_pready;
    endsequence

    sequence s_one_wait_answer;
        o_pready ##1 !o_pready;
    endsequence

    a_rst_no_ticks: assert property (o_device_reset |-> !o_cpu_clk_en && !o_periph_clk_en)
        else $error("clock pulse while device held in reset");
    a_rst_not_ready: assert property (o_device_reset |-> !o_cpu_ready)
        else $error("cpu ready while device held in reset");
    a_ready_after_rst: assert property ($fell(o_device_reset) |-> ##[0:25] o_cpu_ready)
        else $error("cpu ready late after reset release");
    a_ready_gates_cpu: assert property (!o_cpu_ready |-> !o_cpu_clk_en)
        else $error("cpu clock before ready");
    a_cpu_needs_periph: assert property (o_cpu_clk_en |-> o_periph_clk_en)
        else $error("cpu clock without peripheral clock");
    a_tick_single: assert property (o_periph_clk_en |=> !o_periph_clk_en)
        else $error("peripheral clock pulse longer than one cycle");
    a_bus_answer: assert property (s_wait_answer |=> s_one_wait_answer)
        else $error("register access not answered after one wait");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("error response without ready");
endmodule : pmc_checker

bind pmc_top pmc_checker pmc_checker_i (.i_sys_clk, .i_arst_n, .i_psel, .i_penable, .o_pready,
    .o_pslverr, .o_device_reset, .o_cpu_ready, .o_cpu_clk_en, .o_periph_clk_en);

//--- pmc_tb_top.sv
// Purpose: Self-checking bench for the power mode and clock switch controller.
// Assumes: PLL crystal primary; oscillators are bench dividers gated by the enables.
// Notes: Primary period 4 cycles, secondary 8, internal 16.
module pmc_tb_top import pmc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PLL_P = 50;
    localparam int POWER_UP_P = 40;
    logic clk, arst_n, psel, penable, pwrite, sleep, wake, wdt_en, pri_in, t1_in, lf_in, p6;
    logic p6_oe_n;
    logic [3:0] cfg;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, dev_rst, cpu_rdy, cpu_ck, per_ck, pri_en, t1_en, lf_en, po, po_oe_n;
    logic [3:0] div;
    int mismatches, n_compared;

    pmc_top #(.PLL_LOCK_CYCLES_P(PLL_P), .POWER_UP_CYCLES_P(POWER_UP_P)) pmc_top_i (
        .i_sys_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_osc_pin_in(pri_in), .i_t1_osc_in(t1_in),
        .i_internal_lf_osc_in(lf_in), .i_primary_osc_config(cfg),
        .i_power_up_timer_enable_n(1'b0), .i_two_speed_enable(1'b0), .i_wdt_enable(wdt_en),
        .i_fscm_enable(1'b0), .i_sleep_exec(sleep), .i_wake(wake), .i_port_bit6_out(p6),
        .i_port_bit6_oe_n(p6_oe_n), .o_device_reset(dev_rst), .o_cpu_ready(cpu_rdy),
        .o_cpu_clk_en(cpu_ck), .o_periph_clk_en(per_ck), .o_pri_osc_en(pri_en),
        .o_t1_osc_en(t1_en), .o_internal_lf_osc_en(lf_en), .o_osc_pin_out(po),
        .o_osc_pin_out_oe_n(po_oe_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Oscillators only run while the block enables them.
    always @(posedge clk) begin
        div <= div + 4'h1;
        pri_in <= pri_en & div[1];
        t1_in <= t1_en & div[2];
        lf_in <= lf_en & div[3];
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] d, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 2, "bus answer one wait");
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd

    task automatic ticks(input int cyc, output int nc, output int np);
        nc = 0;
        np = 0;
        repeat (cyc) begin
            @(posedge clk);
            nc += int'(cpu_ck === 1'b1);
            np += int'(per_ck === 1'b1);
        end
    endtask : ticks

    task automatic wait_src(input logic [1:0] s);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(PM_STATUS_ADDR, d);
            n++;
        end while (d[1:0] !== s && n < 3000);
        chk({30'h0, d[1:0]}, {30'h0, s}, "active source");
    endtask : wait_src

    task automatic pulse(input logic w);
        if (w) begin
            wake <= 1'b1;
        end else begin
            sleep <= 1'b1;
        end
        @(posedge clk);
        wake <= 1'b0;
        sleep <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse

    task automatic t_powerup();
        int n;
        logic [31:0] d;
        n = 0;
        chk({31'h0, dev_rst}, 32'h1, "held in reset");
        while (dev_rst !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, n >= 4096 + PLL_P}, 32'h1, "start-up hold length");
        repeat (25) @(posedge clk);
        chk({31'h0, cpu_rdy}, 32'h1, "cpu ready");
        rd(OSC_CTRL_ADDR, d);
        chk(d, 32'h8, "osc control after reset");
    endtask : t_powerup

    task automatic t_regs();
        logic [31:0] d;
        logic e;
        wr(OSC_CTRL_ADDR, 32'hf4);
        rd(OSC_CTRL_ADDR, d);
        chk(d, 32'h88, "osc control fields");
        apb(1'b0, 8'h0c, 32'h0, d, e);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(d, 32'h0, "unmapped data");
    endtask : t_regs

    task automatic t_sec();
        logic [31:0] d;
        int nc, np;
        wr(OSC_CTRL_ADDR, 32'h81);
        repeat (60) @(posedge clk);
        rd(PM_STATUS_ADDR, d);
        chk({30'h0, d[1:0]}, 32'h0, "no switch with timer1 off");
        wr(T1_CTRL_ADDR, 32'h8);
        wait_src(SRC_T1);
        rd(T1_CTRL_ADDR, d);
        chk(d, 32'h48, "secondary flag");
        rd(OSC_CTRL_ADDR, d);
        chk(d, 32'h81, "primary flag cleared");
        ticks(80, nc, np);
        chk({31'h0, np >= 9 && np <= 11}, 32'h1, "secondary tick rate");
        chk({31'h0, pri_en}, 32'h0, "primary stopped");
    endtask : t_sec

    task automatic t_int();
        logic [31:0] d;
        int nc, np;
        wr(OSC_CTRL_ADDR, 32'h83);
        wait_src(SRC_INT);
        rd(OSC_CTRL_ADDR, d);
        chk(d, 32'h83, "internal select");
        rd(T1_CTRL_ADDR, d);
        chk(d, 32'h8, "secondary flag off");
        ticks(160, nc, np);
        chk({31'h0, np >= 9 && np <= 11}, 32'h1, "internal tick rate");
    endtask : t_int

    task automatic t_pri();
        logic [31:0] d;
        int nc, np;
        wdt_en <= 1'b1;
        wr(OSC_CTRL_ADDR, 32'h80);
        ticks(200, nc, np);
        chk({31'h0, np >= 10}, 32'h1, "clocked while primary starts");
        wait_src(SRC_PRI);
        rd(OSC_CTRL_ADDR, d);
        chk(d, 32'h88, "back on primary");
        chk({31'h0, lf_en}, 32'h1, "internal kept for watchdog");
    endtask : t_pri

    task automatic t_sleep();
        logic [31:0] d;
        int nc, np;
        pulse(1'b0);
        ticks(80, nc, np);
        chk(nc, 0, "cpu stopped in idle");
        chk({31'h0, np >= 19}, 32'h1, "peripherals clocked in idle");
        pulse(1'b1);
        repeat (30) @(posedge clk);
        ticks(40, nc, np);
        chk({31'h0, nc > 0}, 32'h1, "cpu resumes after wake");
        wr(OSC_CTRL_ADDR, 32'h0);
        pulse(1'b0);
        ticks(80, nc, np);
        chk(np, 0, "no clocks in sleep");
        rd(PM_STATUS_ADDR, d);
        chk({30'h0, d[7:6]}, 32'h2, "sleep taken on new idle value");
        rd(OSC_CTRL_ADDR, d);
        chk(d, 32'h0, "flags cleared in sleep");
        pulse(1'b1);
    endtask : t_sleep

    task automatic t_pin();
        repeat (30) @(posedge clk);
        cfg <= CFG_EXT_CLOCK_CLKOUT;
        p6 <= 1'b1;
        p6_oe_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk({31'h0, po_oe_n}, 32'h0, "clkout pin driven");
        while (po !== 1'b1) begin
            @(posedge clk);
        end
        pulse(1'b0);
        chk({31'h0, po}, 32'h0, "clkout pin low in sleep");
        pulse(1'b1);
        cfg <= CFG_EXT_CLOCK_IO;
        repeat (30) @(posedge clk);
        pulse(1'b0);
        chk({30'h0, po_oe_n, po}, 32'h1, "port bit kept in sleep");
    endtask : t_pin

    task automatic summarize();
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, sleep, wake, wdt_en, p6} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        div = 4'h0;
        cfg = CFG_PLL_CRYSTAL;
        p6_oe_n = 1'b1;
        mismatches = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_powerup();
        t_regs();
        t_sec();
        t_int();
        t_pri();
        t_sleep();
        t_pin();
        summarize();
    end

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("ERROR %0t run did not finish", $time);
        summarize();
    end
endmodule : pmc_tb_top
